// File: src/tcc_params.svh
// timing counts, field codes and fixed values for the timer channel
// assumes inclusion by bare name from the timer package and modules
`ifndef TCC_PARAMS_SVH
`define TCC_PARAMS_SVH

// operating modes carried by op_mode_hi/op_mode_lo
`define TCC_MODE_STOP   2'b00
`define TCC_MODE_FREE   2'b01
`define TCC_MODE_EDGECL 2'b10
`define TCC_MODE_MATCH  2'b11

// count clock select codes and prescaler masks
`define TCC_PRE_DIV2    2'b00
`define TCC_PRE_DIV4    2'b01
`define TCC_PRE_DIV16   2'b10
`define TCC_PRE_PIN     2'b11
`define TCC_MASK_DIV2   8'h01
`define TCC_MASK_DIV4   8'h03
`define TCC_MASK_DIV16  8'h0f
// filter sampling rate while the pin is the count clock
`define TCC_MASK_FILT   8'h03

// edge select codes
`define TCC_EDGE_FALL   2'b00
`define TCC_EDGE_RISE   2'b01
`define TCC_EDGE_NONE   2'b10
`define TCC_EDGE_BOTH   2'b11

// counter values
`define TCC_CNT_ZERO    16'h0000
`define TCC_CNT_ONE     16'h0001
`define TCC_CNT_MAX     16'hffff
`define TCC_RST_PRE     8'h00

`endif

// File: src/tcc_pkg.sv
// types shared by the timer channel modules
// assumes tcc_params.svh is on the include path
package tcc_pkg;
  `include "tcc_params.svh"

  // static configuration written by software
  typedef struct packed {
    logic [1:0] op_mode;        // op_mode_hi, op_mode_lo
    logic [1:0] prescaler_edge_select;
    logic [1:0] edge_sel_a;     // edge_sel_a_high, edge_sel_a_low
    logic [1:0] edge_sel_b;
    logic       cap_mode_zero;  // 1: capture_compare_zero captures
    logic       cap_mode_one;   // 1: capture_compare_one captures
    logic       reverse_phase_capture;
    logic       one_shot_en;
  } tcc_cfg_t;

  // one-shot output sequencer
  typedef enum logic [1:0] {
    TCC_OSP_IDLE   = 2'b00,
    TCC_OSP_ARMED  = 2'b01,
    TCC_OSP_ACTIVE = 2'b11
  } tcc_osp_t;
endpackage

// File: src/tcc_edge_filter.sv
// two-sample noise filter and edge detector for one trigger pin
// assumes pin synchronous to clk; sample_en is a one-cycle pulse
module tcc_edge_filter (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic sample_en_i,
  input  wire logic pin_i,
  output logic      rise_o,
  output logic      fall_o
);
  import tcc_pkg::*;

  logic [1:0] samp;   // last two samples
  logic       lvl;    // accepted level, zero after reset and after two low samples
  logic       next_lvl;

  // accept a level once seen on two sampling clocks in a row
  assign next_lvl = (samp == 2'b11) ? 1'b1 :
                    (samp == 2'b00) ? 1'b0 : lvl;

  // lvl starts low, so a high pin right after reset reads as a rise
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      samp   <= 2'b00;
      lvl    <= 1'b0;
      rise_o <= 1'b0;
      fall_o <= 1'b0;
    end else begin
      if (sample_en_i) begin
        samp <= {samp[0], pin_i};
      end
      lvl    <= next_lvl;
      rise_o <= next_lvl & ~lvl;
      fall_o <= ~next_lvl & lvl;
    end
  end

  AST_FILT_TWO: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    rise_o |-> $past(samp) == 2'b11 && $past(lvl) == 1'b0)
    else $error("rise without two high samples");
endmodule

// File: src/tcc_timer_channel.sv
// one 16-bit timer/event counter channel with two capture/compare
// registers, overflow flag, one-shot output and filtered pin edges
// assumes one clock, pins synchronous to it, control bits as ports
// Operation
// - first match may come up to one count clock late after start
// - capture during a read still happens and interrupts; read sees old value
// - compare register contents are undefined after the channel stops
// - overflow flag also sets when match clears counter from FFFFH
// - overflow flag clear before counter reaches 0001H is overridden
// - one-shot works in free-run and edge-clear modes, not match-clear
// - capture triggered by pin a fails when pin a is count clock
// - capture on count clock fall, interrupt on next count clock rise
// - reverse phase: no capture-zero interrupt; pin-b edge gives interrupt
// - high pin at first enable after reset reads as a rising edge
// - pin-a filter samples at clock/4 as count clock, else count clock
// - a valid edge needs the new level on two samples running
module tcc_timer_channel (
  input  wire logic            core_clk_i,
  input  wire logic            rst_n_i,
  input  wire tcc_pkg::tcc_cfg_t cfg_i,
  input  wire logic            trigger_input_a_i,
  input  wire logic            trigger_input_b_i,
  input  wire logic            cmp_wr_i,
  input  wire logic            cmp_sel_i,
  input  wire logic [15:0]     cmp_data_i,
  input  wire logic            rd_i,
  input  wire logic            rd_sel_i,
  input  wire logic            ovf_clr_i,
  input  wire logic            one_shot_trig_i,
  output logic [15:0]          rd_data_o,
  output logic [15:0]          timer_count_value_o,
  output logic                 overflow_flag_o,
  output logic                 match_capture_irq_zero_o,
  output logic                 match_capture_irq_one_o,
  output logic                 timer_output_pin_o
);
  import tcc_pkg::*;

  // edge select decode, shared by both pins and the reverse phase path
  function automatic logic edge_hit(input logic [1:0] sel,
                                    input logic       rise,
                                    input logic       fall);
    edge_hit = (sel == `TCC_EDGE_RISE) ? rise :
               (sel == `TCC_EDGE_FALL) ? fall :
               (sel == `TCC_EDGE_BOTH) ? (rise | fall) : 1'b0;
  endfunction

  logic [1:0]  rst_sync;
  logic        rst_n;
  logic [7:0]  pre;
  logic [7:0]  pre_mask;
  logic [15:0] count;
  logic [15:0] cr0;
  logic [15:0] cr1;
  logic        pin_tick_d;
  logic        pcap0;
  logic        pcap1;
  logic        pirq0;
  logic        pirq1;
  logic        ovf_hold;
  logic        ever_run;
  tcc_osp_t    osp;
  tcc_osp_t    next_osp;
  logic [1:0]  smp_en;
  logic [1:0]  pin_raw;
  logic [1:0]  rise;
  logic [1:0]  fall;

  // reset release through two flops, assertion stays asynchronous
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // configuration decode
  wire run     = cfg_i.op_mode != `TCC_MODE_STOP;
  wire pin_cnt = cfg_i.prescaler_edge_select == `TCC_PRE_PIN;
  wire rev     = cfg_i.reverse_phase_capture;
  wire m_match = cfg_i.op_mode == `TCC_MODE_MATCH;
  wire m_edgec = cfg_i.op_mode == `TCC_MODE_EDGECL;

  // free-running prescaler; never aligned to start, so the first
  // count tick lands anywhere within one count period
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pre <= `TCC_RST_PRE;
    end else begin
      pre <= pre + 8'h01;
    end
  end

  // count clock rise and fall pulses, internal or from pin a
  assign pre_mask =
    (cfg_i.prescaler_edge_select == `TCC_PRE_DIV2) ? `TCC_MASK_DIV2 :
    (cfg_i.prescaler_edge_select == `TCC_PRE_DIV4) ? `TCC_MASK_DIV4 :
    `TCC_MASK_DIV16;
  wire int_rise = (pre & pre_mask) == pre_mask;
  wire int_fall = (pre & pre_mask) == (pre_mask >> 1);
  wire filt_en  = (pre & `TCC_MASK_FILT) == `TCC_MASK_FILT;
  wire a_hit    = edge_hit(cfg_i.edge_sel_a, rise[0], fall[0]);
  wire b_hit    = edge_hit(cfg_i.edge_sel_b, rise[1], fall[1]);
  // reverse phase capture uses the edge opposite to the selected one
  wire a_rev    = edge_hit(cfg_i.edge_sel_a, fall[0], rise[0]);
  wire tick_r   = pin_cnt ? (a_hit & run) : int_rise;
  wire tick_f   = pin_cnt ? pin_tick_d : int_fall;

  // filters hold their reset level until the first enable, so a pin
  // already high then reads as a rise; afterwards they keep sampling, except pin b while pin a clocks a stopped channel
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ever_run <= 1'b0;
    end else if (run) begin
      ever_run <= 1'b1;
    end
  end
  wire filt_on = ever_run | run;

  // pin a samples at clock/4 as count clock, else at the count clock
  assign smp_en[0] = filt_on & (pin_cnt ? filt_en : tick_r);
  assign smp_en[1] = filt_on & tick_r;
  assign pin_raw   = {trigger_input_b_i, trigger_input_a_i};

  // one filter per trigger pin; the filters run while stopped, pin b only
  // with an internal count clock, so a stop and re-enable shows no false edge
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_filt
      tcc_edge_filter u_filt (
        .clk_i       (core_clk_i),
        .rst_n_i     (rst_n),
        .sample_en_i (smp_en[gi]),
        .pin_i       (pin_raw[gi]),
        .rise_o      (rise[gi]),
        .fall_o      (fall[gi])
      );
    end
  endgenerate

  // compare matches on the count clock rise
  wire match0 = tick_r & run & ~cfg_i.cap_mode_zero & (count == cr0);
  wire match1 = tick_r & run & ~cfg_i.cap_mode_one & (count == cr1);
  // a zero compare value would clear every tick in this mode
  wire clr_match = m_match & match0;
  wire clr_edge  = m_edgec & run & a_hit;
  wire ovf_evt   = tick_r & run & (count == `TCC_CNT_MAX);

  // capture triggers; pin a cannot trigger while it is the count clock
  wire trig0 = run & cfg_i.cap_mode_zero &
               (rev ? (a_rev & ~pin_cnt) : b_hit);
  wire trig1 = run & cfg_i.cap_mode_one & a_hit & ~pin_cnt;
  // in reverse phase a pin-b edge only raises the zero interrupt
  wire ext0  = run & cfg_i.cap_mode_zero & rev & b_hit;

  // counter; stop clears it, match or pin-a edge restarts it
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      count <= `TCC_CNT_ZERO;
    end else if (!run || clr_edge) begin
      count <= `TCC_CNT_ZERO;
    end else if (tick_r) begin
      count <= clr_match ? `TCC_CNT_ZERO : count + `TCC_CNT_ONE;
    end
  end

  // capture pending flags: edge arms, count clock fall captures,
  // next count clock rise raises the interrupt
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pcap0 <= 1'b0;
      pcap1 <= 1'b0;
      pirq0 <= 1'b0;
      pirq1 <= 1'b0;
      pin_tick_d <= 1'b0;
    end else begin
      pin_tick_d <= pin_cnt & a_hit & run;
      pcap0 <= trig0 | (pcap0 & ~tick_f);
      pcap1 <= trig1 | (pcap1 & ~tick_f);
      // reverse phase capture raises no interrupt of its own
      pirq0 <= (tick_f & pcap0 & ~rev) | ext0 |
               (pirq0 & ~tick_r);
      pirq1 <= (tick_f & pcap1) | (pirq1 & ~tick_r);
    end
  end

  // compare registers: software write or capture; a capture in the
  // same cycle as a read still lands, the read sees the old value
  // contents after stop are left as they are and carry no meaning
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cr0 <= `TCC_CNT_ZERO;
      cr1 <= `TCC_CNT_ZERO;
    end else begin
      if (tick_f & pcap0) begin
        cr0 <= count;
      end else if (cmp_wr_i & ~cmp_sel_i) begin
        cr0 <= cmp_data_i;
      end
      if (tick_f & pcap1) begin
        cr1 <= count;
      end else if (cmp_wr_i & cmp_sel_i) begin
        cr1 <= cmp_data_i;
      end
    end
  end

  // read data register
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_o <= `TCC_CNT_ZERO;
    end else if (rd_i) begin
      rd_data_o <= rd_sel_i ? cr1 : cr0;
    end
  end

  // interrupt pulses on the count clock rise
  assign match_capture_irq_zero_o = match0 | (tick_r & pirq0);
  assign match_capture_irq_one_o  = match1 | (tick_r & pirq1);
  assign timer_count_value_o      = count;

  // overflow: a wrap or a match clear from the top value sets it; it
  // cannot be cleared until the counter leaves zero; set beats clear
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ovf_hold        <= 1'b0;
      overflow_flag_o <= 1'b0;
    end else begin
      ovf_hold <= ovf_evt | (ovf_hold & run & ~tick_r);
      overflow_flag_o <= ovf_evt | ovf_hold |
                         (overflow_flag_o & ~ovf_clr_i);
    end
  end

  // one-shot: trigger arms, match one drives active, match zero ends;
  // triggers while active are ignored; no one-shot in match-clear mode
  wire osp_ok = cfg_i.one_shot_en &
                (cfg_i.op_mode == `TCC_MODE_FREE | m_edgec);
  always_comb begin
    next_osp = osp;
    case (osp)
      TCC_OSP_IDLE: begin
        if (one_shot_trig_i) begin
          next_osp = TCC_OSP_ARMED;
        end
      end
      TCC_OSP_ARMED: begin
        if (tick_r & run & (count == cr1)) begin
          next_osp = TCC_OSP_ACTIVE;
        end
      end
      TCC_OSP_ACTIVE: begin
        if (tick_r & run & (count == cr0)) begin
          next_osp = TCC_OSP_IDLE;
        end
      end
      default: next_osp = TCC_OSP_IDLE;
    endcase
    if (!osp_ok) begin
      next_osp = TCC_OSP_IDLE;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      osp                <= TCC_OSP_IDLE;
      timer_output_pin_o <= 1'b0;
    end else begin
      osp                <= next_osp;
      timer_output_pin_o <= next_osp == TCC_OSP_ACTIVE;
    end
  end

  AST_START_TICK: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    (run && !tick_r && !clr_edge) |=> $stable(count))
    else $error("counter moved without a count tick");

  AST_OVF_MATCH: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    (clr_match && count == `TCC_CNT_MAX) |=>
      overflow_flag_o && count == `TCC_CNT_ZERO)
    else $error("match clear from top did not set overflow");

  AST_OVF_STICK: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    (ovf_evt ##1 (ovf_clr_i && count == `TCC_CNT_ZERO)) |=>
      overflow_flag_o)
    else $error("overflow cleared before counter left zero");

  AST_OSP_MODE: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    (m_match ##1 m_match) |-> !timer_output_pin_o)
    else $error("one-shot output in match-clear mode");

  AST_PIN_CAP: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    (pin_cnt && cfg_i.cap_mode_one && !cmp_wr_i) |=> $stable(cr1))
    else $error("pin-a capture while pin a is count clock");

  AST_CAP_TIME: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    (tick_f && pcap1) |=> cr1 == $past(count) && pirq1)
    else $error("capture not taken on count clock fall");

  AST_REV_IRQ: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    (rev && tick_f && pcap0 && !ext0 && !pirq0) |=> !pirq0)
    else $error("reverse phase capture raised an interrupt");

  AST_FILT_RATE: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    (pin_cnt && smp_en[0]) |=> (!pin_cnt || !smp_en[0])[*3])
    else $error("pin-a filter sampled at wrong rate");

  AST_READ_CAP: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    (rd_i && tick_f && pcap0 && !rev) |=> pirq0 && cr0 == $past(count))
    else $error("capture lost during read");
endmodule

// File: sim/tcc_pin_src.sv
// far-side source of the two trigger pins of the timer channel
// assumes the bench clock; levels change 1 ns after a rising edge
module tcc_pin_src (
  input  wire logic clk_i,
  output logic      pin_a_o,
  output logic      pin_b_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // set both pin levels at once, also used at time zero
  task automatic level(input logic a, input logic b);
    pin_a_o = a;
    pin_b_o = b;
  endtask

  // high for hi cycles then low for lo cycles, on pin a or pin b
  // widths stay above two count clocks except deliberate glitches
  task automatic pulse(input bit on_b, input int hi, input int lo);
    @(posedge clk_i);
    #1;
    if (on_b) pin_b_o = 1'b1;
    else pin_a_o = 1'b1;
    repeat (hi) @(posedge clk_i);
    #1;
    if (on_b) pin_b_o = 1'b0;
    else pin_a_o = 1'b0;
    repeat (lo) @(posedge clk_i);
    #1;
  endtask
endmodule

// File: sim/tb.sv
// self-checking bench of the timer channel: start-up edge, match
// clear, capture, reverse phase, pin clock, one-shot and overflow
// assumes tcc_pkg is compiled first and tcc_pin_src drives the pins
`include "tcc_params.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tcc_pkg::*;
  logic        core_clk_i, rst_n_i, cmp_wr_i, cmp_sel_i, rd_i, rd_sel_i;
  logic        ovf_clr_i, one_shot_trig_i, pin_a, pin_b;
  logic        ovf, irq0, irq1, osp;
  logic [15:0] cmp_data_i, rd_data_o, cnt, d, d2, at;
  tcc_cfg_t    cfg_i;
  int          n_fail = 0, n_checks = 0, seed = 14484;
  int          n_irq0 = 0, n_irq1 = 0, n_hi = 0, c, m, k, n0;

  tcc_timer_channel tcc_timer_channel_inst (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .cfg_i(cfg_i),
    .trigger_input_a_i(pin_a), .trigger_input_b_i(pin_b),
    .cmp_wr_i(cmp_wr_i), .cmp_sel_i(cmp_sel_i), .cmp_data_i(cmp_data_i),
    .rd_i(rd_i), .rd_sel_i(rd_sel_i), .ovf_clr_i(ovf_clr_i),
    .one_shot_trig_i(one_shot_trig_i), .rd_data_o(rd_data_o),
    .timer_count_value_o(cnt), .overflow_flag_o(ovf),
    .match_capture_irq_zero_o(irq0), .match_capture_irq_one_o(irq1),
    .timer_output_pin_o(osp)
  );
  tcc_pin_src tcc_pin_src_inst (
    .clk_i(core_clk_i), .pin_a_o(pin_a), .pin_b_o(pin_b)
  );

  // 250 MHz clock
  initial begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end

  // running tallies of interrupt pulses and active output cycles
  always @(posedge core_clk_i) begin
    if (irq0 === 1'b1) n_irq0++;
    if (irq1 === 1'b1) n_irq1++;
    if (osp === 1'b1) n_hi++;
  end

  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  task automatic wr(input logic sel, input logic [15:0] v);
    cmp_wr_i = 1'b1;
    cmp_sel_i = sel;
    cmp_data_i = v;
    cyc(1);
    cmp_wr_i = 1'b0;
    cyc(1);
  endtask

  task automatic rd(input logic sel, output logic [15:0] v);
    rd_i = 1'b1;
    rd_sel_i = sel;
    cyc(1);
    rd_i = 1'b0;
    v = rd_data_o;
  endtask

  // cycles until irq zero pulses, lim + 1 if never; count kept in at
  task automatic wait_irq(input int lim, output int n);
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (n <= lim && irq0 !== 1'b1);
    at = cnt;
  endtask

  task automatic wait_cnt(input logic [15:0] v, input int lim);
    int i;
    i = 0;
    while (cnt !== v && i < lim) begin
      cyc(1);
      i++;
    end
    chk(cnt, v);
  endtask

  // watchdog reckoned from the long overflow run
  initial begin
    #900000;
    n_fail++;
    $display("BAD %0t watchdog expired", $time);
    results();
  end

  initial begin
    {cmp_wr_i, cmp_sel_i, rd_i, rd_sel_i, ovf_clr_i, one_shot_trig_i} = '0;
    cmp_data_i = 16'h0000;
    cfg_i = '0;
    cfg_i.prescaler_edge_select = `TCC_PRE_DIV2;
    cfg_i.edge_sel_a = `TCC_EDGE_NONE;
    cfg_i.edge_sel_b = `TCC_EDGE_RISE;
    cfg_i.cap_mode_zero = 1'b1;
    tcc_pin_src_inst.level(1'b0, 1'b1);
    rst_n_i = 1'b0;
    cyc(16);
    rst_n_i = 1'b1;
    cyc(20); // enable well after reset
    chk(cnt, 16'h0000);
    chk({ovf, irq0, irq1, osp}, 16'h0000);
    // pin b high at first enable gives an edge, not after a restart
    cfg_i.op_mode = `TCC_MODE_FREE;
    wait_irq(40, c);
    chk(c <= 40, 1'b1); // first enable
    cfg_i.op_mode = `TCC_MODE_STOP;
    cyc(4);
    cfg_i.op_mode = `TCC_MODE_FREE;
    n0 = n_irq0;
    cyc(60);
    chk(n_irq0 - n0, 0); // restart
    // match-clear with random nonzero compare values
    cfg_i.op_mode = `TCC_MODE_STOP;
    tcc_pin_src_inst.level(1'b0, 1'b0);
    cfg_i.cap_mode_zero = 1'b0;
    m = 3 + $unsigned($random(seed)) % 18;
    k = 1 + $unsigned($random(seed)) % (m - 1);
    wr(1'b0, m[15:0]); // nonzero
    wr(1'b1, k[15:0]); // nonzero
    cfg_i.op_mode = `TCC_MODE_MATCH;
    wait_irq(200, c);
    chk(c >= 2 * m && c <= 2 * m + 3, 1'b1); // start
    n0 = n_irq1;
    wait_irq(200, c);
    chk(c, 2 * m + 2); // period
    chk(n_irq1 - n0, 1); // one match
    // pin b capture while a read is held, then a one-cycle glitch
    cfg_i.op_mode = `TCC_MODE_STOP;
    cyc(2);
    cfg_i.prescaler_edge_select = `TCC_PRE_DIV4;
    cfg_i.cap_mode_zero = 1'b1;
    cfg_i.op_mode = `TCC_MODE_FREE;
    cyc(20);
    rd_sel_i = 1'b0;
    rd_i = 1'b1;
    fork
      tcc_pin_src_inst.pulse(1'b1, 12, 20);
      wait_irq(60, c);
    join
    cyc(1);
    rd_i = 1'b0;
    chk(c <= 60, 1'b1); // irq despite read
    chk(rd_data_o, at); // captured value
    n0 = n_irq0;
    tcc_pin_src_inst.pulse(1'b1, 1, 30);
    chk(n_irq0 - n0, 0); // glitch
    // reverse phase: pin b only interrupts, pin a fall captures zero silently, rise captures one with irq
    cfg_i.op_mode = `TCC_MODE_STOP;
    cyc(2);
    cfg_i.reverse_phase_capture = 1'b1;
    cfg_i.edge_sel_a = `TCC_EDGE_RISE; // while stopped
    cfg_i.cap_mode_one = 1'b1;
    cfg_i.op_mode = `TCC_MODE_FREE;
    cyc(20);
    rd(1'b0, d);
    n0 = n_irq0;
    tcc_pin_src_inst.pulse(1'b1, 12, 30);
    rd(1'b0, d2);
    chk(n_irq0 - n0, 1); // pin b irq
    chk(d2, d); // no capture
    n0 = n_irq0;
    k = n_irq1;
    tcc_pin_src_inst.pulse(1'b0, 12, 30);
    chk(n_irq0 - n0, 0); // silent capture
    chk(n_irq1 - k, 1); // pin a capture irq
    rd(1'b0, d);
    chk(d != d2, 1'b1); // reverse capture landed
    // pin a as count clock: glitch rejected, pin a captures dropped
    cfg_i.op_mode = `TCC_MODE_STOP;
    cyc(2);
    cfg_i.reverse_phase_capture = 1'b0;
    cfg_i.prescaler_edge_select = `TCC_PRE_PIN;
    cfg_i.cap_mode_one = 1'b1;
    cfg_i.op_mode = `TCC_MODE_FREE;
    m = 2 + $unsigned($random(seed)) % 5;
    n0 = n_irq1;
    tcc_pin_src_inst.pulse(1'b0, 1, 16);
    repeat (m) tcc_pin_src_inst.pulse(1'b0, 16, 16);
    cyc(16);
    chk(cnt, m[15:0]); // pin edges counted
    chk(n_irq1 - n0, 0); // captures dropped
    // one-shot in free-run and edge-clear, refused in match-clear
    cfg_i.op_mode = `TCC_MODE_STOP;
    cyc(2);
    cfg_i.prescaler_edge_select = `TCC_PRE_DIV2;
    cfg_i.cap_mode_zero = 1'b0;
    cfg_i.cap_mode_one = 1'b0;
    cfg_i.edge_sel_a = `TCC_EDGE_NONE; // while stopped
    cfg_i.one_shot_en = 1'b1;
    wr(1'b1, 16'h0008);
    wr(1'b0, 16'h0010);
    for (int i = 1; i < 4; i++) begin
      cfg_i.op_mode = i[1:0];
      cyc(2);
      n0 = n_hi;
      one_shot_trig_i = 1'b1; // output idle
      cyc(1);
      one_shot_trig_i = 1'b0;
      cyc(60);
      chk(n_hi - n0, i < 3 ? 16 : 0); // pulse width
      cfg_i.op_mode = `TCC_MODE_STOP;
      cyc(2);
    end
    // match-clear at FFFF sets the flag; an early clear is overridden
    cfg_i.one_shot_en = 1'b0;
    wr(1'b1, 16'h0001);
    wr(1'b0, 16'hffff);
    cfg_i.op_mode = `TCC_MODE_MATCH;
    wait_cnt(16'hffff, 140000);
    wait_cnt(16'h0000, 4);
    ovf_clr_i = 1'b1;
    cyc(1);
    ovf_clr_i = 1'b0;
    chk(ovf, 1'b1); // flag set
    cyc(1);
    chk(ovf, 1'b1); // early clear lost
    wait_cnt(16'h0002, 8);
    ovf_clr_i = 1'b1;
    cyc(1);
    ovf_clr_i = 1'b0;
    cyc(1);
    chk(ovf, 1'b0); // later clear works
    results();
  end
endmodule
